// ==== hw/mac_power_sync_mgmt.sv ====
// Behaviour
// R01: An accepted anchor-enable request makes the capabilities element advertise anchor ability.
// R02: With anchor on, the beacon carries the anchor element once a neighbour's hibernation element arrived.
// R03: Each received beacon anchor element raises an anchor-received indication.
// R04: Every anchor enable or disable request gets exactly one SUCCESS or FAILURE confirm.
// R05: A sleep schedule request replaces the stored slot bitmap and updates the availability element.
// R06: The receiver stays awake in every slot marked active and may sleep in the others.
// R07: Each sleep schedule request produces one confirm with its result.
// R08: A sync request for a group activates the mechanism and is followed by one confirm.
// R09: Once active, every data frame sent or received to the registered group raises an indication.
// R10: The indication is timed from the start of the matching frame on the medium.
// R11: An indication is raised only when the PHY reports the frame as successful.
// R12: The indication carries group address, sender address and sequence number.
// R13: The sync confirm is NOT_SUPPORTED, with no activation, if unsupported or not multicast; the code confirms RES_FAILURE instead.
// R14: The anchor request selects start or stop with a two-valued selector.
// R15: The power policy is always on, on per schedule or on per load.
// R16: The contention slot limit caps awake contention slots per superframe, 0 to 255.
// R17: One outstanding request per family, confirmed before the next one is taken.
`timescale 1ns/10ps
module mac_power_sync_mgmt
  import mac_pwr_sync_pkg::*;
#(
  parameter logic ANCHOR_SUPPORTED = 1'b1,
  parameter logic SYNC_SUPPORTED = 1'b1
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic rx_hib_ie,
  input wire logic rx_anchor_ie,
  output logic cap_anchor,
  output logic beacon_anchor_ie,
  output logic anchor_ind,
  output logic pca_avail_update,
  output logic [SLOTS-1:0] pca_avail_map,
  input wire logic slot_tick,
  input wire logic [SLOT_W-1:0] slot_index,
  input wire logic superframe_start,
  input wire logic pca_slot,
  input wire logic nbr_hard_slot,
  input wire logic nbr_soft_slot,
  output logic rx_awake,
  input wire logic frame_start,
  input wire frame_info_t frame_info,
  input wire logic phy_done,
  input wire logic phy_ok,
  output logic sync_ind,
  output sync_ind_t sync_ind_data
);
  logic ready_reg, rd_ok;
  logic [31:0] prdata_reg, rd_word;
  logic wr_en, cmd_wr;
  logic anchor_pend_reg, anchor_sel_reg, anchor_on_reg, hib_seen_reg, anchor_res_reg;
  logic sleep_pend_reg, sleep_res_reg, sync_pend_reg, sync_on_reg, sync_res_reg;
  logic [15:0] cfg_stage_reg;
  logic [MAP_WORDS-1:0][31:0] map_stage_reg;
  logic [SLOTS-1:0] map_active_reg;
  rx_power_policy_t policy_reg;
  logic pca_en_reg, hard_reg, soft_reg;
  logic [7:0] limit_reg, pca_used_reg, pca_cnt;
  logic [47:0] grp_stage_reg, grp_reg;
  logic [INT_W-1:0] int_stat_reg, int_en_reg, int_set;
  logic [STAMP_W-1:0] stamp_reg;
  logic cand_reg;
  sync_ind_t cand_data_reg;
  logic policy_ok, sync_ok, pca_grant, sched_bit;
  // Zero-wait access: read data is registered in the setup cycle
  assign pready = ce & penable & ready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pready & ~rd_ok;
  assign wr_en = psel & pready & pwrite & rd_ok;
  assign cmd_wr = wr_en & (paddr == OFF_CMD);
  always_comb
  begin
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      OFF_CMD: rd_word = 32'h0000_0000;
      OFF_SLEEP_CFG: rd_word = {16'h0000, cfg_stage_reg};
      OFF_GRP_LO: rd_word = grp_stage_reg[31:0];
      OFF_GRP_HI: rd_word = {16'h0000, grp_stage_reg[47:32]};
      OFF_STATE: rd_word = {21'h00_0000, sleep_pend_reg, sync_pend_reg, anchor_pend_reg,
                            2'b00, sync_on_reg, hib_seen_reg, anchor_on_reg,
                            sync_res_reg, sleep_res_reg, anchor_res_reg};
      OFF_INT_STAT: rd_word = {27'h000_0000, int_stat_reg};
      OFF_INT_CLR: rd_word = 32'h0000_0000;
      OFF_INT_EN: rd_word = {27'h000_0000, int_en_reg};
      OFF_IND_SRC_LO: rd_word = sync_ind_data.sender_addr[31:0];
      OFF_IND_SRC_HI: rd_word = {16'h0000, sync_ind_data.sender_addr[47:32]};
      OFF_IND_SEQ: rd_word = {20'h0_0000, sync_ind_data.seq};
      OFF_IND_STAMP: rd_word = sync_ind_data.stamp;
      default:
      begin
        rd_ok = (paddr >= OFF_MAP_BASE) && (paddr < OFF_MAP_END) && (paddr[1:0] == 2'b00);
        rd_word = rd_ok ? map_stage_reg[paddr[MAP_IDX_W+1:2]] : 32'h0000_0000;
      end
    endcase
  end
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      ready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else if (ce)
    begin
      ready_reg <= psel & ~pready;
      // Reload while waiting, so a setup cycle lost to a low enable still loads data
      if (psel & ~pready)
        prdata_reg <= rd_word;
    end
  end
  // Staging registers and the interrupt enable; a request reads the staging ones when it is processed
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      cfg_stage_reg <= 16'h0000;
      grp_stage_reg <= 48'h0000_0000_0000;
      map_stage_reg <= '0;
      int_en_reg <= 5'h00;
    end
    else if (ce & wr_en)
    begin
      if (paddr == OFF_SLEEP_CFG)
        cfg_stage_reg <= pwdata[15:0];
      if (paddr == OFF_GRP_LO)
        grp_stage_reg[31:0] <= pwdata;
      if (paddr == OFF_GRP_HI)
        grp_stage_reg[47:32] <= pwdata[15:0];
      if (paddr == OFF_INT_EN)
        int_en_reg <= pwdata[INT_W-1:0];
      if (paddr >= OFF_MAP_BASE && paddr < OFF_MAP_END)
        map_stage_reg[paddr[MAP_IDX_W+1:2]] <= pwdata;
    end
  end
  // Anchor family
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      anchor_pend_reg <= 1'b0;
      anchor_sel_reg <= 1'b0;
      anchor_on_reg <= 1'b0;
      anchor_res_reg <= RES_SUCCESS;
      hib_seen_reg <= 1'b0;
      anchor_ind <= 1'b0;
    end
    else if (ce)
    begin
      anchor_ind <= rx_anchor_ie; // R03
      if (anchor_pend_reg)
      begin
        anchor_pend_reg <= 1'b0; // R04
        anchor_res_reg <= ANCHOR_SUPPORTED ? RES_SUCCESS : RES_FAILURE; // R04
        if (ANCHOR_SUPPORTED)
          anchor_on_reg <= anchor_sel_reg; // R14
      end
      else if (cmd_wr & pwdata[CMD_ANCHOR_REQ])
      begin
        anchor_pend_reg <= 1'b1; // R17
        anchor_sel_reg <= pwdata[CMD_ANCHOR_SEL];
      end
      // Forget the neighbour once anchoring stops, so a restart waits for a fresh one
      if (!anchor_on_reg)
        hib_seen_reg <= 1'b0;
      else if (rx_hib_ie)
        hib_seen_reg <= 1'b1; // R02
    end
  end
  assign cap_anchor = anchor_on_reg; // R01
  assign beacon_anchor_ie = anchor_on_reg & hib_seen_reg; // R02
  // Sleep schedule family
  assign policy_ok = cfg_stage_reg[CFG_POLICY_LSB+1:CFG_POLICY_LSB] != 2'b11; // R15
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sleep_pend_reg <= 1'b0;
      sleep_res_reg <= RES_SUCCESS;
      policy_reg <= POLICY_ALWAYS_ON;
      pca_en_reg <= 1'b0;
      hard_reg <= 1'b0;
      soft_reg <= 1'b0;
      limit_reg <= 8'h00;
      map_active_reg <= '0;
      pca_avail_update <= 1'b0;
    end
    else if (ce)
    begin
      pca_avail_update <= 1'b0;
      if (sleep_pend_reg)
      begin
        sleep_pend_reg <= 1'b0; // R07
        sleep_res_reg <= policy_ok ? RES_SUCCESS : RES_FAILURE; // R07
        if (policy_ok)
        begin
          policy_reg <= rx_power_policy_t'(cfg_stage_reg[CFG_POLICY_LSB+1:CFG_POLICY_LSB]);
          pca_en_reg <= cfg_stage_reg[CFG_PCA];
          hard_reg <= cfg_stage_reg[CFG_HARD];
          soft_reg <= cfg_stage_reg[CFG_SOFT];
          limit_reg <= cfg_stage_reg[CFG_LIMIT_LSB+7:CFG_LIMIT_LSB]; // R16
          map_active_reg <= map_stage_reg; // R05
          pca_avail_update <= 1'b1; // R05
        end
      end
      else if (cmd_wr & pwdata[CMD_SLEEP_REQ])
        sleep_pend_reg <= 1'b1; // R17
    end
  end
  assign pca_avail_map = map_active_reg;
  assign pca_cnt = superframe_start ? 8'h00 : pca_used_reg;
  assign sched_bit = map_active_reg[slot_index];
  assign pca_grant = pca_en_reg & pca_slot & (pca_cnt < limit_reg); // R16
  // Awake decision is registered, so it settles one cycle after the slot tick
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      rx_awake <= 1'b1;
      pca_used_reg <= 8'h00;
    end
    else if (ce)
    begin
      if (superframe_start)
        pca_used_reg <= 8'h00;
      if (slot_tick)
      begin
        unique case (policy_reg)
          POLICY_ALWAYS_ON: rx_awake <= 1'b1; // R15
          POLICY_PER_SCHEDULE: rx_awake <= sched_bit; // R06
          POLICY_PER_LOAD:
          begin
            rx_awake <= sched_bit | pca_grant | (hard_reg & nbr_hard_slot) |
                        (soft_reg & nbr_soft_slot); // R06
            if (pca_grant)
              pca_used_reg <= pca_cnt + 8'h01; // R16
          end
          default: rx_awake <= 1'b1;
        endcase
      end
    end
  end
  // Sync family
  assign sync_ok = SYNC_SUPPORTED & grp_stage_reg[MCAST_BIT]; // R13
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      sync_pend_reg <= 1'b0;
      sync_on_reg <= 1'b0;
      sync_res_reg <= RES_SUCCESS;
      grp_reg <= 48'h0000_0000_0000;
    end
    else if (ce)
    begin
      if (sync_pend_reg)
      begin
        sync_pend_reg <= 1'b0; // R08
        sync_res_reg <= sync_ok ? RES_SUCCESS : RES_FAILURE; // R13
        sync_on_reg <= sync_ok; // R13
        if (sync_ok)
          grp_reg <= grp_stage_reg; // R08
      end
      else if (cmd_wr & pwdata[CMD_SYNC_REQ])
        sync_pend_reg <= 1'b1; // R17
    end
  end
  // Frame matching: fields and time are caught at frame start, reported on PHY success
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      stamp_reg <= 32'h0000_0000;
      cand_reg <= 1'b0;
      cand_data_reg <= '0;
      sync_ind <= 1'b0;
      sync_ind_data <= '0;
    end
    else if (ce)
    begin
      stamp_reg <= stamp_reg + 32'h0000_0001;
      sync_ind <= 1'b0;
      if (phy_done)
      begin
        cand_reg <= 1'b0;
        if (cand_reg & phy_ok)
        begin
          sync_ind <= 1'b1; // R11
          sync_ind_data <= cand_data_reg; // R12
        end
      end
      if (frame_start)
      begin
        cand_reg <= sync_on_reg & frame_info.is_data &
                    (frame_info.destination_field == grp_reg); // R09
        cand_data_reg.sync_group_addr <= grp_reg; // R12
        cand_data_reg.sender_addr <= frame_info.sender_addr; // R12
        cand_data_reg.seq <= frame_info.seq; // R12
        cand_data_reg.stamp <= stamp_reg; // R10
      end
    end
  end
  // Interrupts: a new event beats a clear in the same cycle
  assign int_set = {sync_ind, anchor_ind, sync_pend_reg, sleep_pend_reg, anchor_pend_reg};
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      int_stat_reg <= 5'h00;
    else if (ce)
    begin
      if (wr_en && paddr == OFF_INT_CLR)
        int_stat_reg <= (int_stat_reg & ~pwdata[INT_W-1:0]) | int_set;
      else
        int_stat_reg <= int_stat_reg | int_set;
    end
  end
  assign irq = |(int_stat_reg & int_en_reg);

  a_cap_after_cnf: assert property (@(posedge ref_clk) disable iff (reset) // R01
    (ce && anchor_pend_reg && anchor_sel_reg && ANCHOR_SUPPORTED) |=> cap_anchor)
    else $error("anchor capability not advertised after enable");
  a_beacon_anchor: assert property (@(posedge ref_clk) disable iff (reset) // R02
    (ce && anchor_on_reg && rx_hib_ie && !anchor_pend_reg) |=> beacon_anchor_ie)
    else $error("anchor element missing from beacon");
  a_anchor_ind: assert property (@(posedge ref_clk) disable iff (reset) // R03
    (ce && rx_anchor_ie) |=> anchor_ind ##1 int_stat_reg[INT_ANCHOR_IND])
    else $error("anchor indication not raised");
  a_anchor_one_cnf: assert property (@(posedge ref_clk) disable iff (reset) // R04
    (ce && anchor_pend_reg) |=> (!anchor_pend_reg && int_stat_reg[INT_ANCHOR_CNF]))
    else $error("anchor confirm not issued once");
  a_sleep_apply: assert property (@(posedge ref_clk) disable iff (reset) // R05
    (ce && sleep_pend_reg && policy_ok) |=>
      (pca_avail_update && map_active_reg == $past(map_stage_reg)))
    else $error("sleep schedule not applied");
  a_awake_sched: assert property (@(posedge ref_clk) disable iff (reset) // R06
    (ce && slot_tick && policy_reg == POLICY_PER_SCHEDULE && sched_bit) |=> rx_awake)
    else $error("receiver asleep in active slot");
  a_sleep_cnf: assert property (@(posedge ref_clk) disable iff (reset) // R07
    (ce && sleep_pend_reg) |=> (!sleep_pend_reg && int_stat_reg[INT_SLEEP_CNF]))
    else $error("sleep confirm missing");
  a_sync_refuse: assert property (@(posedge ref_clk) disable iff (reset) // R13
    (ce && sync_pend_reg && !grp_stage_reg[MCAST_BIT]) |=>
      (!sync_on_reg && sync_res_reg == RES_FAILURE))
    else $error("non-multicast group activated");
  a_sync_phy_ok: assert property (@(posedge ref_clk) disable iff (reset) // R11
    $rose(sync_ind) |-> $past(phy_done && phy_ok && cand_reg))
    else $error("sync indication without PHY success");
  a_sync_group: assert property (@(posedge ref_clk) disable iff (reset) // R12
    $rose(sync_ind) |-> (sync_ind_data.sync_group_addr == grp_reg))
    else $error("sync indication carries wrong group");
  a_pca_limit: assert property (@(posedge ref_clk) disable iff (reset) // R16
    (ce && slot_tick && policy_reg == POLICY_PER_LOAD && pca_grant) |=>
      (pca_used_reg <= limit_reg))
    else $error("contention slot limit exceeded");
endmodule : mac_power_sync_mgmt

// ==== hw/mac_pwr_sync_pkg.sv ====
package mac_pwr_sync_pkg;
  localparam int ADDR_W = 8;
  localparam int SLOTS = 256;
  localparam int SLOT_W = 8;
  localparam int MAP_WORDS = SLOTS / 32;
  localparam int MAP_IDX_W = 3;
  localparam logic [ADDR_W-1:0] OFF_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SLEEP_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_GRP_LO = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_GRP_HI = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATE = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_INT_STAT = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_INT_CLR = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_INT_EN = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_IND_SRC_LO = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_IND_SRC_HI = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_IND_SEQ = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_IND_STAMP = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_MAP_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_MAP_END = 8'h60;
  localparam int CMD_ANCHOR_REQ = 0;
  localparam int CMD_ANCHOR_SEL = 1;
  localparam int CMD_SLEEP_REQ = 2;
  localparam int CMD_SYNC_REQ = 3;
  localparam int CFG_POLICY_LSB = 0;
  localparam int CFG_PCA = 2;
  localparam int CFG_HARD = 3;
  localparam int CFG_SOFT = 4;
  localparam int CFG_LIMIT_LSB = 8;
  localparam int INT_ANCHOR_CNF = 0;
  localparam int INT_SLEEP_CNF = 1;
  localparam int INT_SYNC_CNF = 2;
  localparam int INT_ANCHOR_IND = 3;
  localparam int INT_SYNC_IND = 4;
  localparam int INT_W = 5;
  localparam int MCAST_BIT = 40;
  localparam int SEQ_W = 12;
  localparam int STAMP_W = 32;
  typedef enum logic [1:0] {
    POLICY_ALWAYS_ON = 2'b00,
    POLICY_PER_SCHEDULE = 2'b01,
    POLICY_PER_LOAD = 2'b10
  } rx_power_policy_t;
  typedef enum logic {RES_SUCCESS = 1'b0, RES_FAILURE = 1'b1} result_t;
  typedef struct packed {
    logic is_data;
    logic [47:0] destination_field;
    logic [47:0] sender_addr;
    logic [SEQ_W-1:0] seq;
  } frame_info_t;
  typedef struct packed {
    logic [47:0] sync_group_addr;
    logic [47:0] sender_addr;
    logic [SEQ_W-1:0] seq;
    logic [STAMP_W-1:0] stamp;
  } sync_ind_t;
endpackage : mac_pwr_sync_pkg

// ==== tb/mac_power_sync_mgmt_bench.sv ====
`timescale 1ns/10ps
module mac_power_sync_mgmt_bench;
  import mac_pwr_sync_pkg::*;
  typedef struct packed {logic err; logic [31:0] mask; logic [31:0] val;} rd_note_t;
  typedef struct packed {logic [47:0] grp; logic [47:0] src; logic [SEQ_W-1:0] seq;
    logic [31:0] at;} ind_note_t;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tick_d = 1'b0, have_base = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, base;
  logic pready, pslverr, irq, rx_hib_ie, rx_anchor_ie, cap_anchor, beacon_anchor_ie;
  logic anchor_ind, pca_avail_update, slot_tick, superframe_start, pca_slot, nbr_hard_slot;
  logic nbr_soft_slot, rx_awake, frame_start, phy_done, phy_ok, sync_ind;
  logic [SLOTS-1:0] pca_avail_map, exp_map;
  logic [SLOT_W-1:0] slot_index, idx;
  logic [31:0] m[MAP_WORDS];
  logic [47:0] grp;
  frame_info_t frame_info, fi;
  sync_ind_t sync_ind_data;
  int num_errors = 0, total_checks = 0, cyc = 0;
  rd_note_t rn;
  ind_note_t inn;
  rd_note_t rd_q[$];
  ind_note_t ind_q[$];
  logic awake_q[$], anchor_q[$];
  logic [SLOTS-1:0] map_q[$];
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  mac_power_sync_mgmt u_mac_power_sync_mgmt (.ref_clk(ref_clk), .reset(reset), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .rx_hib_ie(rx_hib_ie),
    .rx_anchor_ie(rx_anchor_ie), .cap_anchor(cap_anchor), .beacon_anchor_ie(beacon_anchor_ie),
    .anchor_ind(anchor_ind), .pca_avail_update(pca_avail_update), .pca_avail_map(pca_avail_map),
    .slot_tick(slot_tick), .slot_index(slot_index), .superframe_start(superframe_start),
    .pca_slot(pca_slot), .nbr_hard_slot(nbr_hard_slot), .nbr_soft_slot(nbr_soft_slot),
    .rx_awake(rx_awake), .frame_start(frame_start), .frame_info(frame_info),
    .phy_done(phy_done), .phy_ok(phy_ok), .sync_ind(sync_ind), .sync_ind_data(sync_ind_data));
  phy_beacon_model u_phy_beacon_model (.ref_clk(ref_clk), .rx_hib_ie(rx_hib_ie),
    .rx_anchor_ie(rx_anchor_ie), .slot_tick(slot_tick), .slot_index(slot_index),
    .superframe_start(superframe_start), .pca_slot(pca_slot), .nbr_hard_slot(nbr_hard_slot),
    .nbr_soft_slot(nbr_soft_slot), .frame_start(frame_start), .frame_info(frame_info),
    .phy_done(phy_done), .phy_ok(phy_ok));
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      num_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(n < 50, "bus timeout");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
    if (n >= 50)
      final_report();
  endtask : apb
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] k, input logic [31:0] v,
    input logic e = 1'b0);
    rd_q.push_back('{e, k, v});
    apb(1'b0, a, '0);
  endtask : rd
  // Observer: every result that appears consumes the oldest matching note
  always @(posedge ref_clk)
  begin
    if (psel && penable && pready && !pwrite && rd_q.size() > 0)
    begin
      rn = rd_q.pop_front();
      chk((prdata & rn.mask) === rn.val && pslverr === rn.err, "read data");
    end
    if (sync_ind === 1'b1)
    begin
      chk(ind_q.size() > 0, "unexpected sync indication");
      if (ind_q.size() > 0)
      begin
        inn = ind_q.pop_front();
        chk(sync_ind_data.sync_group_addr === inn.grp && sync_ind_data.sender_addr === inn.src
          && sync_ind_data.seq === inn.seq, "sync content");
        if (!have_base)
          base = sync_ind_data.stamp - inn.at;
        have_base = 1'b1;
        chk(sync_ind_data.stamp - inn.at === base, "stamp not at frame start");
      end
    end
    if (anchor_ind === 1'b1)
      chk(anchor_q.size() > 0 && anchor_q.pop_front(), "unexpected anchor indication");
    if (pca_avail_update === 1'b1)
      chk(map_q.size() > 0 && pca_avail_map === map_q.pop_front(), "availability map");
    if (tick_d)
      chk(awake_q.size() > 0 && rx_awake === awake_q.pop_front(), "receiver wake");
    tick_d <= slot_tick;
  end
  initial
  begin
    void'($urandom(79145));
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    chk(rx_awake === 1'b1 && cap_anchor === 1'b0 && irq === 1'b0, "reset levels");
    wr(OFF_INT_EN, 32'h1f);
    wr(OFF_CMD, 32'h3);
    repeat (2) @(posedge ref_clk);
    chk(cap_anchor === 1'b1 && irq === 1'b1 && beacon_anchor_ie === 1'b0, "anchor on");
    rd(OFF_STATE, 32'h709, 32'h8);
    u_phy_beacon_model.beacon(1'b1, 1'b0);
    @(posedge ref_clk);
    chk(beacon_anchor_ie === 1'b1, "anchor element");
    anchor_q.push_back(1'b1);
    u_phy_beacon_model.beacon(1'b0, 1'b1);
    wr(OFF_CMD, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(cap_anchor === 1'b0 && beacon_anchor_ie === 1'b0, "anchor off");
    rd(OFF_STATE, 32'h709, 32'h0);
    wr(OFF_INT_EN, 32'h0);
    chk(irq === 1'b0, "masked interrupt");
    wr(OFF_INT_CLR, 32'h1f);
    // Enable held low over the setup cycle: the access must wait for it
    ce <= 1'b0;
    fork
      rd(OFF_INT_STAT, 32'h1f, 32'h0);
      begin
        repeat (3) @(posedge ref_clk);
        ce <= 1'b1;
      end
    join
    wr(OFF_INT_EN, 32'h1f);
    $display("test anchor done");
    for (int i = 0; i < MAP_WORDS; i++)
    begin
      m[i] = $urandom;
      wr(OFF_MAP_BASE + ADDR_W'(4 * i), m[i]);
    end
    // Policies 0..2 each apply a changed map; code 3 is refused and applies nothing
    for (int p = 0; p < 4; p++)
    begin
      m[7] = m[7] ^ 32'h1;
      if (p == 2)
        m[0] = '0;
      wr(OFF_MAP_BASE, m[0]);
      wr(OFF_MAP_END - 8'h4, m[7]);
      for (int i = 0; i < MAP_WORDS; i++)
        exp_map[32 * i +: 32] = m[i];
      if (p < 3)
        map_q.push_back(exp_map);
      wr(OFF_SLEEP_CFG, p == 2 ? 32'h10e : 32'(p));
      wr(OFF_CMD, 32'h4);
      repeat (2) @(posedge ref_clk);
      rd(OFF_STATE, 32'h402, p == 3 ? 32'h2 : 32'h0);
      for (int k = 0; k < 5 && p < 3; k++)
      begin
        idx = (p == 2) ? SLOT_W'(k + 1) : SLOT_W'($urandom);
        awake_q.push_back(p == 0 ? 1'b1 : p == 1 ? exp_map[idx] : (k % 2 == 0));
        u_phy_beacon_model.slot(idx, p == 2 && (k == 0 || k == 4),
          p == 2 ? 3'(k == 3 ? 1 : k == 2 ? 2 : 4) : 3'b000);
      end
    end
    $display("test sleep done");
    for (int g = 0; g < 2; g++)
    begin
      grp = 48'({$urandom, $urandom});
      grp[MCAST_BIT] = g[0];
      wr(OFF_GRP_LO, grp[31:0]);
      wr(OFF_GRP_HI, {16'h0, grp[47:32]});
      wr(OFF_CMD, 32'h8);
      repeat (2) @(posedge ref_clk);
      rd(OFF_STATE, 32'h224, g ? 32'h20 : 32'h4);
      for (int j = 0; j < 5; j++)
      begin
        fi.is_data = (j != 2);
        fi.destination_field = (j == 3) ? grp ^ 48'h1 : grp;
        fi.sender_addr = 48'({$urandom, $urandom});
        fi.seq = SEQ_W'($urandom);
        if (g == 1 && (j == 0 || j == 4))
          ind_q.push_back('{grp, fi.sender_addr, fi.seq, cyc});
        u_phy_beacon_model.frame(fi, 2 + 3 * j, j != 1);
      end
    end
    rd(OFF_INT_STAT, 32'h16, 32'h16);
    rd(8'h30, 32'hffffffff, 32'h0, 1'b1);
    $display("test sync done");
    repeat (5) @(posedge ref_clk);
    chk(rd_q.size() + ind_q.size() + awake_q.size() + anchor_q.size() + map_q.size() == 0,
      "missing results");
    final_report();
  end
endmodule : mac_power_sync_mgmt_bench

// ==== tb/phy_beacon_model.sv ====
`timescale 1ns/10ps
module phy_beacon_model
  import mac_pwr_sync_pkg::*;
(
  input wire logic ref_clk,
  output logic rx_hib_ie,
  output logic rx_anchor_ie,
  output logic slot_tick,
  output logic [SLOT_W-1:0] slot_index,
  output logic superframe_start,
  output logic pca_slot,
  output logic nbr_hard_slot,
  output logic nbr_soft_slot,
  output logic frame_start,
  output frame_info_t frame_info,
  output logic phy_done,
  output logic phy_ok
);
  initial
  begin
    {rx_hib_ie, rx_anchor_ie, slot_tick, superframe_start} = '0;
    {pca_slot, nbr_hard_slot, nbr_soft_slot, frame_start, phy_done, phy_ok} = '0;
    slot_index = '0;
    frame_info = '0;
  end
  task automatic beacon(input logic hib, input logic anchor);
    rx_hib_ie <= hib;
    rx_anchor_ie <= anchor;
    @(posedge ref_clk);
    rx_hib_ie <= 1'b0;
    rx_anchor_ie <= 1'b0;
  endtask : beacon
  // Qualifiers are {contention, neighbour hard, neighbour soft} and stay for the slot
  task automatic slot(input logic [SLOT_W-1:0] idx, input logic sf, input logic [2:0] qual);
    slot_tick <= 1'b1;
    slot_index <= idx;
    superframe_start <= sf;
    {pca_slot, nbr_hard_slot, nbr_soft_slot} <= qual;
    @(posedge ref_clk);
    slot_tick <= 1'b0;
    superframe_start <= 1'b0;
    @(posedge ref_clk);
  endtask : slot
  task automatic frame(input frame_info_t fi, input int len, input logic ok);
    frame_start <= 1'b1;
    frame_info <= fi;
    @(posedge ref_clk);
    frame_start <= 1'b0;
    // Descriptor is only valid with the start pulse, so scramble it afterwards
    frame_info <= ~fi;
    repeat (len) @(posedge ref_clk);
    phy_done <= 1'b1;
    phy_ok <= ok;
    @(posedge ref_clk);
    phy_done <= 1'b0;
    phy_ok <= ~ok;
  endtask : frame
endmodule : phy_beacon_model
